// [pmsvc_loader.sv]
// Top of the preload loader: fetches the six preload words in order,
// merges them into per-port fields and serves configuration reads.
// Assumes the memory answers each request with a one-cycle ack pulse and
// that all inputs are synchronous to clk_in.
`default_nettype none

module pmsvc_loader #(
  parameter int NUM_PORTS = pmsvc_pkg::NUM_PORTS
) (
  input  wire logic                      clk_in,
  input  wire logic                      rst_in,
  input  wire pmsvc_pkg::pmsvc_mem_rsp_t mem_rsp_in,
  output var  pmsvc_pkg::pmsvc_mem_req_t mem_req_out,
  input  wire pmsvc_pkg::pmsvc_cfg_req_t cfg_req_in,
  output var  pmsvc_pkg::pmsvc_cfg_rsp_t cfg_rsp_out,
  output var  pmsvc_pkg::pmsvc_ports_t   ports_out,
  output var  logic [5:0]                present_out,
  output var  logic                      ready_out
);
  import pmsvc_pkg::*;

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  // The word map and the read decode are laid out for exactly three ports
  if (NUM_PORTS != pmsvc_pkg::NUM_PORTS) begin : g_bad_ports
    $error("pmsvc_loader supports exactly three ports");
  end

  // ****************************************************************
  // State and decoder
  // ****************************************************************
  pmsvc_regs_t  s_r;
  pmsvc_regs_t  s_nxt;
  pmsvc_ports_t dec_ports;
  logic         word_taken;
  logic         word_used;

  // Memory answer accepted only while loading
  assign word_taken = (s_r.state == ST_LOAD) && mem_rsp_in.ack;
  assign word_used  = word_taken && !mem_rsp_in.absent;

  pmsvc_word_decode u_decode (
    .idx_in    (s_r.idx),
    .data_in   (mem_rsp_in.data),
    .ports_in  (s_r.ports),
    .ports_out (dec_ports)
  );

  // ****************************************************************
  // Register image of one port
  // ****************************************************************
  // Unmapped offsets and bits read as zero, except D1 and D2 support which read as one; only this block's fields show
  function automatic logic [31:0] reg_image(input pmsvc_port_t f,
                                            input logic [11:0] off);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (off)
      OFF_PM_CAPABILITY: begin
        d[R_AUX_LSB +: 3] = f.aux_current;
        d[R_D1]           = 1'b1;
        d[R_D2]           = 1'b1;
        d[R_PME_LSB +: 2] = f.pme_d2d1;
        d[R_DSI]          = f.dsi;
      end
      OFF_PM_CONTROL_DATA: begin
        d[R_PMDATA_LSB +: 8] = f.pm_data;
        d[R_NSR]             = f.no_soft_reset;
      end
      OFF_EXPRESS_CAP: begin
        d[R_SLOT_IMPL] = f.slot_impl;
      end
      OFF_LINK_CAPABILITY: begin
        d[R_PNUM_LSB +: 3] = f.port_num;
      end
      OFF_LINK_STAT_CTRL: begin
        d[R_SLOT_CLK] = f.slot_clock;
      end
      OFF_VC_PORT_CAP: begin
        d[R_LOW_PRIORITY_VC_COUNT] = f.low_priority_vc_count;
      end
      OFF_VC0_RES_CTRL: begin
        d[R_TCMAP_LSB +: 7] = f.tc_map;
      end
      default: begin
        d = 32'h0000_0000;
      end
    endcase
    return d;
  endfunction

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // Loading runs straight out of reset; reads are dropped unanswered until the last word is in
  always_comb begin
    s_nxt         = s_r;
    s_nxt.cfg.ack = 1'b0;
    case (s_r.state)
      ST_LOAD: begin
        if (word_taken) begin
          // An absent word leaves the defaults in place
          if (!mem_rsp_in.absent) begin
            s_nxt.ports            = dec_ports;
            s_nxt.present[s_r.idx] = 1'b1;
          end
          if (s_r.idx == IDX_LAST) begin
            s_nxt.state    = ST_DONE;
            s_nxt.mem.req  = 1'b0;
            s_nxt.ready    = 1'b1;
          end else begin
            s_nxt.idx      = 3'(s_r.idx + 3'h1);
            s_nxt.mem.addr = PRELOAD_SEQ[3'(s_r.idx + 3'h1)];
          end
        end
      end
      ST_DONE: begin
        // Configuration reads are served only once all words are in
        if (cfg_req_in.en) begin
          s_nxt.cfg.ack = 1'b1;
          if (cfg_req_in.port < 2'(NUM_PORTS)) begin
            s_nxt.cfg.data = reg_image(s_r.ports[cfg_req_in.port], cfg_req_in.off);
          end else begin
            s_nxt.cfg.data = 32'h0000_0000;
          end
        end
      end
      default: begin
        s_nxt.state = ST_LOAD;
      end
    endcase
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_r.state    <= ST_LOAD;
      s_r.idx      <= 3'h0;
      s_r.present  <= '0;
      s_r.ports    <= {NUM_PORTS{RST_PORT}};
      s_r.mem.req  <= 1'b1;
      s_r.mem.addr <= W_P1_PMDATA;
      s_r.cfg      <= '0;
      s_r.ready    <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // Outputs, all straight from the state register
  // ****************************************************************
  assign mem_req_out = s_r.mem;
  assign cfg_rsp_out = s_r.cfg;
  assign ports_out   = s_r.ports;
  assign present_out = s_r.present;
  assign ready_out   = s_r.ready;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // A present word accepted at one index
  sequence s_word_at(logic [2:0] i);
    word_used && (s_r.idx == i);
  endsequence

  // A read request while loading has not finished
  sequence s_early_read;
    cfg_req_in.en && !s_r.ready;
  endsequence

  a_p1_pm_data: assert property (s_word_at(IDX_P1_PMDATA) |=>
    ports_out[1].pm_data == $past(mem_rsp_in.data[15:8]))
    else $error("Port 1 PM data not loaded from its word");

  a_p2_pm_fields: assert property (s_word_at(IDX_P2_PM) |=>
    ports_out[2].no_soft_reset == $past(mem_rsp_in.data[0])
    && ports_out[2].aux_current == $past(mem_rsp_in.data[3:1])
    && ports_out[2].pme_d2d1 == $past(mem_rsp_in.data[7:6]))
    else $error("Port 2 PM capability fields not loaded");

  a_p2_pm_data: assert property (s_word_at(IDX_P2_PMDATA) |=>
    ports_out[2].pm_data == $past(mem_rsp_in.data[15:8]))
    else $error("Port 2 PM data not loaded from its word");

  a_p2_slot_word: assert property (s_word_at(IDX_LAST) |=>
    ports_out[2].slot_impl == $past(mem_rsp_in.data[0])
    && ports_out[2].slot_clock == $past(mem_rsp_in.data[1])
    && ports_out[2].dsi == $past(mem_rsp_in.data[2])
    && ports_out[2].low_priority_vc_count == $past(mem_rsp_in.data[3])
    && ports_out[2].port_num == $past(mem_rsp_in.data[6:4])
    && ports_out[2].tc_map == $past(mem_rsp_in.data[15:9])
    && ports_out[1] == $past(ports_out[1]))
    else $error("Port 2 slot word misapplied");

  a_p0_no_slot: assert property (s_word_at(IDX_SLOT_BASE) |=>
    ports_out[0].slot_impl == $past(ports_out[0].slot_impl)
    && ports_out[0].port_num == $past(mem_rsp_in.data[6:4]))
    else $error("Port 0 slot word touched slot-implemented");

  a_absent_keeps: assert property (word_taken && mem_rsp_in.absent |=>
    $stable(ports_out) && $stable(present_out))
    else $error("Absent word changed loaded fields");

  a_addr_order: assert property (word_taken && (s_r.idx != IDX_LAST) |=>
    mem_req_out.req && mem_req_out.addr == PRELOAD_SEQ[s_r.idx])
    else $error("Preload word address out of order");

  a_ready_at_end: assert property ($rose(ready_out) |->
    $past(word_taken) && $past(s_r.idx) == IDX_LAST && !mem_req_out.req)
    else $error("Ready raised before the last word");

  a_early_refused: assert property (s_early_read |=> !cfg_rsp_out.ack)
    else $error("Config read answered before loading finished");

  a_read_latency: assert property (ready_out && cfg_req_in.en |=>
    cfg_rsp_out.ack)
    else $error("Config read not answered in one cycle");

  a_d1_d2_ones: assert property (ready_out && cfg_req_in.en
    && cfg_req_in.off == OFF_PM_CAPABILITY && cfg_req_in.port < 2'h3 |=>
    cfg_rsp_out.data[R_D2] && cfg_rsp_out.data[R_D1])
    else $error("D1 or D2 support bit not read as one");

  a_fields_frozen: assert property (ready_out |=> $stable(ports_out))
    else $error("Fields changed after loading finished");

  // ****************************************************************
  // Load handshake bookkeeping
  // ****************************************************************
  // The request is a level for the whole load and drops with ready,
  // so the memory never sees a gap between two words
  a_req_level: assert property (mem_req_out.req == !ready_out)
    else $error("Memory request and ready flag disagree");

  // The address must hold while a word is outstanding, otherwise the
  // memory would answer for a word the loader no longer expects
  a_addr_steady: assert property (mem_req_out.req && !word_taken |=>
    mem_req_out.req && $stable(mem_req_out.addr))
    else $error("Preload address moved without an answer");

  // The index never runs past the last word of the sequence
  a_idx_range: assert property (s_r.idx <= IDX_LAST)
    else $error("Load index outside the word sequence");

  // A stray state code would hide a stuck load behind a quiet bus
  a_state_onehot: assert property ($onehot(s_r.state))
    else $error("Loader state not one-hot");

  // Present flags move only for a word that was really applied
  a_present_used: assert property (!word_used |=> $stable(present_out))
    else $error("Present flags moved without a used word");

  // Ready is one-way until the next reset
  a_ready_holds: assert property (ready_out |=> ready_out)
    else $error("Ready dropped without a reset");

  // Port 0 PM fields and port 1 PM fields other than its data byte belong to words outside this loader
  a_pm_port2_only: assert property (ports_out[0].aux_current == 3'h0
    && ports_out[1].aux_current == 3'h0 && ports_out[0].pme_d2d1 == 2'h0
    && ports_out[1].pme_d2d1 == 2'h0 && !ports_out[1].no_soft_reset
    && ports_out[0].pm_data == 8'h00)
    else $error("PM fields of port 0 or 1 were loaded");

  // ****************************************************************
  // Read answers
  // ****************************************************************
  // Field set of the port that the current read names; port 3 has none
  pmsvc_port_t rd_port;
  assign rd_port = (cfg_req_in.port == 2'h3) ? RST_PORT : ports_out[cfg_req_in.port];

  // A served read at one mapped offset of ports 0 to 2
  sequence s_read_at(logic [11:0] o);
    ready_out && cfg_req_in.en && cfg_req_in.off == o && cfg_req_in.port != 2'h3;
  endsequence

  // No answer without a served request; a stray pulse would be taken
  // by the host as the answer to its next read
  a_ack_needs_req: assert property (!(ready_out && cfg_req_in.en) |=> !cfg_rsp_out.ack)
    else $error("Config answer without a served request");

  // Read data holds between answers so a slow host can still take it
  a_data_holds: assert property (!cfg_req_in.en |=> $stable(cfg_rsp_out.data))
    else $error("Config read data changed between answers");

  // Capability word: aux current, PME support and initialisation flag
  a_cap_image: assert property (s_read_at(OFF_PM_CAPABILITY) |=>
    cfg_rsp_out.data[R_AUX_LSB +: 3] == $past(rd_port.aux_current)
    && cfg_rsp_out.data[R_PME_LSB +: 2] == $past(rd_port.pme_d2d1)
    && cfg_rsp_out.data[R_DSI] == $past(rd_port.dsi))
    else $error("PM capability image wrong");

  // Control word: data byte and the soft-reset flag
  a_ctl_image: assert property (s_read_at(OFF_PM_CONTROL_DATA) |=>
    cfg_rsp_out.data[R_PMDATA_LSB +: 8] == $past(rd_port.pm_data)
    && cfg_rsp_out.data[R_NSR] == $past(rd_port.no_soft_reset))
    else $error("PM control and data image wrong");

  // Single-field registers: the whole word is checked, so a stray bit
  // from a neighbouring field cannot slip through
  a_slot_image: assert property (s_read_at(OFF_EXPRESS_CAP) |=>
    cfg_rsp_out.data == (32'($past(rd_port.slot_impl)) << R_SLOT_IMPL))
    else $error("Slot-implemented image wrong");

  a_pnum_image: assert property (s_read_at(OFF_LINK_CAPABILITY) |=>
    cfg_rsp_out.data == (32'($past(rd_port.port_num)) << R_PNUM_LSB))
    else $error("Port number image wrong");

  a_clock_image: assert property (s_read_at(OFF_LINK_STAT_CTRL) |=>
    cfg_rsp_out.data == (32'($past(rd_port.slot_clock)) << R_SLOT_CLK))
    else $error("Slot clock image wrong");

  a_low_priority_vc_count_image: assert property (s_read_at(OFF_VC_PORT_CAP) |=>
    cfg_rsp_out.data == (32'($past(rd_port.low_priority_vc_count)) << R_LOW_PRIORITY_VC_COUNT))
    else $error("Low-priority VC count image wrong");

  a_tcmap_image: assert property (s_read_at(OFF_VC0_RES_CTRL) |=>
    cfg_rsp_out.data == (32'($past(rd_port.tc_map)) << R_TCMAP_LSB))
    else $error("Traffic-class map image wrong");

  // Port 3 does not exist and answers with an empty word
  a_port3_zero: assert property (ready_out && cfg_req_in.en && cfg_req_in.port == 2'h3 |=>
    cfg_rsp_out.data == 32'h0000_0000)
    else $error("Read of port 3 returned data");

endmodule

`default_nettype wire

// [pmsvc_mem_model.sv]
// Behavioural serial configuration memory seen at the word level.
// Assumes the loader's level request and answers with a one-cycle ack pulse.
`default_nettype none

module pmsvc_mem_model (
  input  wire logic                      clk_in,
  input  wire logic                      rst_in,
  input  wire logic [5:0][15:0]          words_in,
  input  wire logic [5:0]                absent_in,
  input  wire logic [3:0]                delay_in,
  input  wire pmsvc_pkg::pmsvc_mem_req_t req_in,
  output var  pmsvc_pkg::pmsvc_mem_rsp_t rsp_out,
  output var  logic                      order_ok_out
);
  import pmsvc_pkg::*;

  logic [3:0] wait_r;
  logic [2:0] n_r;

  // Answers after delay_in idle cycles; data toggles when not valid so
  // a loader that samples outside the ack cannot pass by luck
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rsp_out      <= '0;
      wait_r       <= 4'h0;
      n_r          <= 3'h0;
      order_ok_out <= 1'b1;
    end else begin
      rsp_out.ack    <= 1'b0;
      rsp_out.absent <= 1'b0;
      rsp_out.data   <= ~rsp_out.data;
      if (req_in.req && !rsp_out.ack) begin
        if (wait_r >= delay_in) begin
          rsp_out.ack    <= 1'b1;
          rsp_out.absent <= absent_in[n_r];
          if (!absent_in[n_r]) begin
            rsp_out.data <= words_in[n_r];
          end
          // Word order is fixed; any other address is flagged
          if (req_in.addr !== PRELOAD_SEQ[n_r]) begin
            order_ok_out <= 1'b0;
          end
          n_r    <= n_r + 3'h1;
          wait_r <= 4'h0;
        end else begin
          wait_r <= wait_r + 4'h1;
        end
      end
    end
  end
endmodule

`default_nettype wire

// [pmsvc_pkg.sv]
// Constants, field layouts and carrier types of the power-management and
// slot/virtual-channel preload loader.
// Assumes one 200 MHz core clock and an asynchronous active-high reset.
`default_nettype none

package pmsvc_pkg;

  // ****************************************************************
  // Sizes and preload word addresses
  // ****************************************************************
  localparam int            NUM_PORTS   = 3;
  localparam int            NUM_WORDS   = 6;
  localparam logic [7:0]    W_P1_PMDATA = 8'h53;
  localparam logic [7:0]    W_P2_PM     = 8'h54;
  localparam logic [7:0]    W_P2_PMDATA = 8'h55;
  localparam logic [7:0]    W_P0_SLOT   = 8'h60;
  localparam logic [7:0]    W_P1_SLOT   = 8'h62;
  localparam logic [7:0]    W_P2_SLOT   = 8'h64;
  localparam logic [NUM_WORDS-1:0][7:0] PRELOAD_SEQ =
    {W_P2_SLOT, W_P1_SLOT, W_P0_SLOT, W_P2_PMDATA, W_P2_PM, W_P1_PMDATA};
  localparam logic [2:0]    IDX_P1_PMDATA = 3'h0;
  localparam logic [2:0]    IDX_P2_PM     = 3'h1;
  localparam logic [2:0]    IDX_P2_PMDATA = 3'h2;
  localparam logic [2:0]    IDX_SLOT_BASE = 3'h3;
  localparam logic [2:0]    IDX_LAST      = 3'h5;

  // ****************************************************************
  // Configuration register offsets
  // ****************************************************************
  localparam logic [11:0]   OFF_PM_CAPABILITY   = 12'h040;
  localparam logic [11:0]   OFF_PM_CONTROL_DATA = 12'h044;
  localparam logic [11:0]   OFF_EXPRESS_CAP     = 12'h0c0;
  localparam logic [11:0]   OFF_LINK_CAPABILITY = 12'h0cc;
  localparam logic [11:0]   OFF_LINK_STAT_CTRL  = 12'h0d0;
  localparam logic [11:0]   OFF_VC_PORT_CAP     = 12'h144;
  localparam logic [11:0]   OFF_VC0_RES_CTRL    = 12'h154;

  // ****************************************************************
  // Field positions inside a preload word
  // ****************************************************************
  localparam int            D_PMDATA_LSB = 8;
  localparam int            D_NSR        = 0;
  localparam int            D_AUX_LSB    = 1;
  localparam int            D_PME_LSB    = 6;
  localparam int            D_SLOT_IMPL  = 0;
  localparam int            D_SLOT_CLK   = 1;
  localparam int            D_DSI        = 2;
  localparam int            D_LOW_PRIORITY_VC_COUNT       = 3;
  localparam int            D_PNUM_LSB   = 4;
  localparam int            D_TCMAP_LSB  = 9;

  // ****************************************************************
  // Field positions inside a configuration register
  // ****************************************************************
  localparam int            R_PMDATA_LSB = 24;
  localparam int            R_NSR        = 3;
  localparam int            R_AUX_LSB    = 22;
  localparam int            R_D1         = 25;
  localparam int            R_D2         = 26;
  localparam int            R_PME_LSB    = 28;
  localparam int            R_SLOT_IMPL  = 24;
  localparam int            R_SLOT_CLK   = 28;
  localparam int            R_DSI        = 21;
  localparam int            R_LOW_PRIORITY_VC_COUNT       = 4;
  localparam int            R_PNUM_LSB   = 24;
  localparam int            R_TCMAP_LSB  = 1;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic [7:0] pm_data;
    logic       no_soft_reset;
    logic [2:0] aux_current;
    logic [1:0] pme_d2d1;
    logic       slot_impl;
    logic       slot_clock;
    logic       dsi;
    logic       low_priority_vc_count;
    logic [2:0] port_num;
    logic [6:0] tc_map;
  } pmsvc_port_t;

  typedef pmsvc_port_t [NUM_PORTS-1:0] pmsvc_ports_t;

  localparam pmsvc_port_t RST_PORT = '{8'h00, 1'b0, 3'h0, 2'h0, 1'b0, 1'b0,
                                       1'b0, 1'b0, 3'h0, 7'h00};

  typedef struct packed {
    logic       req;
    logic [7:0] addr;
  } pmsvc_mem_req_t;

  typedef struct packed {
    logic        ack;
    logic        absent;
    logic [15:0] data;
  } pmsvc_mem_rsp_t;

  typedef struct packed {
    logic        en;
    logic [1:0]  port;
    logic [11:0] off;
  } pmsvc_cfg_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] data;
  } pmsvc_cfg_rsp_t;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b01,
    ST_DONE = 2'b10
  } pmsvc_state_t;

  typedef struct packed {
    pmsvc_state_t         state;
    logic [2:0]           idx;
    logic [NUM_WORDS-1:0] present;
    pmsvc_ports_t         ports;
    pmsvc_mem_req_t       mem;
    pmsvc_cfg_rsp_t       cfg;
    logic                 ready;
  } pmsvc_regs_t;

endpackage

`default_nettype wire

// [pmsvc_word_decode.sv]
// Merges one preload word into the per-port field set.
// Assumes the caller only presents a word that the memory really returned.
`default_nettype none

module pmsvc_word_decode (
  input  wire logic [2:0]              idx_in,
  input  wire logic [15:0]             data_in,
  input  wire pmsvc_pkg::pmsvc_ports_t ports_in,
  output var  pmsvc_pkg::pmsvc_ports_t ports_out
);
  import pmsvc_pkg::*;

  // ****************************************************************
  // Field merge, chosen by position in the load sequence
  // ****************************************************************
  always_comb begin
    ports_out = ports_in;
    case (idx_in)
      IDX_P1_PMDATA: begin
        ports_out[1].pm_data = data_in[D_PMDATA_LSB +: 8];
      end
      IDX_P2_PM: begin
        ports_out[2].no_soft_reset = data_in[D_NSR];
        ports_out[2].aux_current   = data_in[D_AUX_LSB +: 3];
        ports_out[2].pme_d2d1      = data_in[D_PME_LSB +: 2];
      end
      IDX_P2_PMDATA: begin
        ports_out[2].pm_data = data_in[D_PMDATA_LSB +: 8];
      end
      default: begin
        // Slot words follow in port order, one word per port
        for (int p = 0; p < NUM_PORTS; p++) begin
          if (idx_in == 3'(IDX_SLOT_BASE + 3'(p))) begin
            // Port 0 has no slot-implemented source in its word
            if (p != 0) begin
              ports_out[p].slot_impl = data_in[D_SLOT_IMPL];
            end
            ports_out[p].slot_clock            = data_in[D_SLOT_CLK];
            ports_out[p].dsi                   = data_in[D_DSI];
            ports_out[p].low_priority_vc_count = data_in[D_LOW_PRIORITY_VC_COUNT];
            ports_out[p].port_num              = data_in[D_PNUM_LSB +: 3];
            ports_out[p].tc_map                = data_in[D_TCMAP_LSB +: 7];
          end
        end
      end
    endcase
  end

endmodule

`default_nettype wire

// [test_pm_slot_vc_config_preload.sv]
// Self-checking bench of the preload loader with a memory model.
// Assumes the loader serves reads only after ready_out rises.
`default_nettype none

`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
  $display("wrong value at %0t ns: got %h want %h", $time, a, b); end end

module test_pm_slot_vc_config_preload;
  timeunit 1ns;
  timeprecision 100ps;
  import pmsvc_pkg::*;

  logic             clk = 1'b0;
  logic             rst = 1'b1;
  pmsvc_mem_rsp_t   mem_rsp;
  pmsvc_mem_req_t   mem_req;
  pmsvc_cfg_req_t   cfg_req = '0;
  pmsvc_cfg_rsp_t   cfg_rsp;
  pmsvc_ports_t     ports;
  logic [5:0]       present;
  logic             ready;
  logic [5:0][15:0] w = '0;
  logic [5:0]       ab = '0;
  logic [3:0]       dly = 4'h0;
  logic             order_ok;
  int               mismatches = 0;
  int               comparisons = 0;
  logic [11:0]      offs [9] = '{12'h040, 12'h044, 12'h0c0, 12'h0cc, 12'h0d0,
                                 12'h144, 12'h154, 12'h048, 12'h000};

  // ****************************************************************
  // Clock, design and memory
  // ****************************************************************
  always #2.5 clk = ~clk;

  pmsvc_loader #(.NUM_PORTS(3)) dut (
    .clk_in(clk), .rst_in(rst), .mem_rsp_in(mem_rsp), .mem_req_out(mem_req),
    .cfg_req_in(cfg_req), .cfg_rsp_out(cfg_rsp), .ports_out(ports),
    .present_out(present), .ready_out(ready));

  pmsvc_mem_model mem (
    .clk_in(clk), .rst_in(rst), .words_in(w), .absent_in(ab), .delay_in(dly),
    .req_in(mem_req), .rsp_out(mem_rsp), .order_ok_out(order_ok));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic tally_and_finish;
    if (mismatches == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Expected image built from the field map; absent words give zero
  function automatic logic [31:0] img(input int p, input logic [11:0] off);
    logic [15:0] s;
    logic [15:0] pm;
    logic [15:0] pd;
    if (p == 3) return 32'h0000_0000;
    s  = ab[3+p] ? 16'h0000 : w[3+p];
    pm = (p == 2 && !ab[1]) ? w[1] : 16'h0000;
    pd = (p == 1 && !ab[0]) ? w[0] : (p == 2 && !ab[2]) ? w[2] : 16'h0000;
    case (off)
      12'h040: return {2'h0, pm[7:6], 1'b0, 2'h3, pm[3:1], s[2], 21'h0};
      12'h044: return {pd[15:8], 20'h0, pm[0], 3'h0};
      12'h0c0: return {7'h0, (p != 0) & s[0], 24'h0};
      12'h0cc: return {5'h0, s[6:4], 24'h0};
      12'h0d0: return {3'h0, s[1], 28'h0};
      12'h144: return {27'h0, s[3], 4'h0};
      12'h154: return {24'h0, s[15:9], 1'b0};
      default: return 32'h0000_0000;
    endcase
  endfunction

  task automatic do_reset;
    @(negedge clk);
    rst = 1'b1;
    repeat (12) @(negedge clk);
    `CHK(ready, 1'b0)
    `CHK(present, 6'h00)
    rst = 1'b0;
  endtask

  // One read; ack must stand exactly one cycle
  task automatic rd(input int p, input logic [11:0] off, input logic [31:0] exp, input logic exp_ack);
    @(negedge clk);
    cfg_req = '{1'b1, p[1:0], off};
    @(negedge clk);
    cfg_req.en = 1'b0;
    `CHK(cfg_rsp.ack, exp_ack)
    if (exp_ack) `CHK(cfg_rsp.data, exp)
    @(negedge clk);
    `CHK(cfg_rsp.ack, 1'b0)
  endtask

  task automatic wait_ready;
    int i;
    for (i = 0; i < 300 && ready !== 1'b1; i++) @(negedge clk);
    if (ready !== 1'b1) begin
      mismatches++;
      $display("wrong value at %0t ns: loader never became ready", $time);
      tally_and_finish();
    end
  endtask

  // Every port, every mapped offset, plus unmapped offsets and port 3
  task automatic check_all(input logic [5:0] exp_present);
    `CHK(present, exp_present)
    `CHK(order_ok, 1'b1)
    `CHK(mem_req.req, 1'b0)
    `CHK(ports[1].pm_data, ab[0] ? 8'h00 : w[0][15:8])
    for (int p = 0; p < 3; p++)
      `CHK(ports[p].tc_map, ab[3+p] ? 7'h00 : w[3+p][15:9])
    for (int p = 0; p < 4; p++)
      for (int k = 0; k < 9; k++) rd(p, offs[k], img(p, offs[k]), 1'b1);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Prompt memory, all words present; an early read must be dropped
  task automatic s_prompt_load;
    w   = '{16'h56ca, 16'hab35, 16'h5a5b, 16'h3cc3, 16'h00ff, 16'ha55a};
    ab  = 6'h00;
    dly = 4'h0;
    do_reset();
    rd(2, 12'h040, 32'h0, 1'b0);
    wait_ready();
    check_all(6'h3f);
  endtask

  // Slow memory, reset in mid-load, alternate words absent
  task automatic s_slow_absent;
    w   = '{16'ha935, 16'h54ca, 16'ha5a4, 16'hc33c, 16'hff00, 16'h5aa5};
    ab  = 6'h15;
    dly = 4'h3;
    do_reset();
    repeat (9) @(negedge clk);
    do_reset();
    wait_ready();
    check_all(6'h2a);
  endtask

  // Only the bits each field owns: complement set, nothing absent
  task automatic s_complement;
    w   = '{16'ha935, 16'h54ca, 16'ha5a4, 16'hc33c, 16'hff00, 16'h5aa5};
    ab  = 6'h00;
    dly = 4'h1;
    do_reset();
    wait_ready();
    check_all(6'h3f);
  endtask

  initial begin
    s_prompt_load();
    s_slow_absent();
    s_complement();
    tally_and_finish();
  end
endmodule

`default_nettype wire
